// file: src/swlcu_defines.vh
// Offsets, field positions, reset values and timing for swing/length/count
// Functional notes
// [RULE1] Output frequency swings around set centre
// [RULE2] Zero wobble amplitude gives plain centre frequency
// [RULE3] Mode 0: swing is centre times amplitude
// [RULE4] Mode 1: swing is maximum times amplitude
// [RULE5] Kick is swing times kick percentage; the code caps the percentage at 50 % (SWLCU_KICK_MAX)
// [RULE6] Wobble frequency clamped between minimum and maximum
// [RULE7] Programmable wobble period, default ten seconds
// [RULE8] Rise time is period times rise coefficient
// [RULE9] Fall time is period times remainder
// [RULE10] Length is pulses divided by pulses-per-meter
// [RULE11] Length arrival when length exceeds target
// [RULE12] Length reset input clears accumulated length
// [RULE13] Length pulses wired to length input
// [RULE14] Count pulses wired to count input
// [RULE15] Final count reached: flag and stop
// [RULE16] Intermediate count reached: flag, keep counting
// [RULE17] Keep intermediate target not above final; the code writes ICNT as given and never checks it against FCNT
// [RULE18] Ramp between bounds, kick step at turns
`ifndef SWLCU_DEFINES_VH
`define SWLCU_DEFINES_VH
`define SWLCU_OFF_REF    8'h00
`define SWLCU_OFF_AMP    8'h04
`define SWLCU_OFF_KICK   8'h08
`define SWLCU_OFF_PER    8'h0C
`define SWLCU_OFF_RISE   8'h10
`define SWLCU_OFF_TLEN   8'h14
`define SWLCU_OFF_MLEN   8'h18
`define SWLCU_OFF_PPM    8'h1C
`define SWLCU_OFF_FCNT   8'h20
`define SWLCU_OFF_ICNT   8'h24
`define SWLCU_OFF_CNT    8'h28
`define SWLCU_OFF_STAT   8'h2C
`define SWLCU_OFF_MASK   8'h30
`define SWLCU_OFF_CTRL   8'h34
`define SWLCU_RST_PER    16'h0064
`define SWLCU_RST_RISE   16'h01F4
`define SWLCU_RST_TLEN   16'h03E8
`define SWLCU_RST_PPM    16'h03E8
`define SWLCU_RST_FCNT   16'h03E8
`define SWLCU_RST_ICNT   16'h03E8
`define SWLCU_PCT_FULL   16'h03E8
`define SWLCU_KICK_MAX   16'h01F4
`define SWLCU_PER_MAX    16'h7530
`define SWLCU_ST_LEN     0
`define SWLCU_ST_FIN     1
`define SWLCU_ST_MID     2
`define SWLCU_CTRL_CCLR  0
`define SWLCU_TICK_NS    1000000
`define SWLCU_CLK_NS     50
`endif

// file: src/swlcu_top.v
// Swing frequency, fixed length and counting unit with APB registers
`timescale 1ns/1ps
`include "swlcu_defines.vh"
module swlcu_top #(
    parameter TICK_CYC = `SWLCU_TICK_NS / `SWLCU_CLK_NS
) (
    input  wire        sys_clk_in,
    input  wire        rst_b_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [7:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    input  wire [15:0] center_freq_in,
    input  wire [15:0] max_freq_in,
    input  wire [15:0] min_freq_in,
    input  wire        count_pulse_in,
    input  wire        length_pulse_in,
    input  wire        length_reset_in,
    output reg  [15:0] freq_out,
    output reg         length_arrive_out,
    output reg         count_final_out,
    output reg         count_mid_out,
    output reg         irq_out
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam DW = 40;
    localparam S_IDLE = 2'b00;
    localparam S_WOB  = 2'b01;
    localparam S_LEN  = 2'b10;
    reg  [15:0] ref_r, amp_r, kick_r, per_r, rise_r, tlen_r;
    reg  [15:0] mlen_r, ppm_r, fcnt_r, icnt_r, cnt_r, mask_r;
    reg  [2:0]  stat_r;
    reg  [31:0] tick_cnt_r;
    reg         tick_r;
    reg  [2:0]  s1_r, s2_r, s3_r;
    reg  [31:0] pulses_r;
    reg         len_dirty_r;
    reg  [21:0] t_r;
    reg         fall_r;
    reg  [1:0]  job_r;
    reg  [5:0]  bit_r;
    reg  [DW-1:0] num_r;
    reg  [DW-1:0] rem_r;
    reg  [21:0] den_r;
    reg  [16:0] woff_r;
    wire [15:0] base;
    wire [31:0] aw_w, kk_w;
    wire [16:0] aw, kick, span;
    wire [21:0] rise_ms, tot_ms, fall_ms, seg_ms;
    wire        wr_en, rd_setup, mapped;
    wire [DW-1:0] rem_sh;
    wire        l_edge, c_edge, lrst;
    reg  [31:0] rd_mux;
    reg  [17:0] f_calc;
    reg         job_fall_r, wfall_r;  // Phase of the offset in use
    wire [31:0] rise_w;
    wire [DW-1:0] q_last;

    // Percentage in tenths applied to a value, result in value units
    function [31:0] pct;
        input [16:0] val;
        input [15:0] p;
        begin
            pct = ({15'h0000, val} * {16'h0000, p}) / 32'h0000_03E8;
        end
    endfunction

    // Saturate a wide quotient to 16 bits
    function [15:0] sat16;
        input [DW-1:0] v;
        begin
            sat16 = (|v[DW-1:16]) ? 16'hFFFF : v[15:0];
        end
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers and edge detect
    // ------------------------------------------------------------
    // Bits: 0 count, 1 length pulse, 2 length reset
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s1_r <= 3'b000;
            s2_r <= 3'b000;
            s3_r <= 3'b000;
        end else begin
            s1_r <= {length_reset_in, length_pulse_in, count_pulse_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign c_edge = s2_r[0] & ~s3_r[0];
    assign l_edge = s2_r[1] & ~s3_r[1];
    assign lrst   = s2_r[2];

    // ------------------------------------------------------------
    // Millisecond tick for the wobble timeline
    // ------------------------------------------------------------
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r >= TICK_CYC - 1) begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
            tick_r     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Swing, kick and segment lengths
    // ------------------------------------------------------------
    assign base = ref_r[0] ? max_freq_in : center_freq_in; // RULE3 RULE4
    assign aw_w = pct({1'b0, base}, amp_r);                // RULE3 RULE4
    assign aw   = aw_w[16:0];
    // Kick above twice the swing would invert the ramp, so cap it
    assign kk_w = pct(aw, (kick_r > `SWLCU_KICK_MAX) ?
                  `SWLCU_KICK_MAX : kick_r);               // RULE5
    assign kick = kk_w[16:0];
    assign span = {aw[15:0], 1'b0} - kick;                 // RULE18
    // Period in 0.1 s, coefficient in 0.1 percent, result in ms
    assign tot_ms  = per_r * 22'd100;                      // RULE7
    // Product needs 25 bits at the longest period, so divide wide
    assign rise_w  = ({16'h0000, per_r} * {16'h0000, rise_r}) /
                     32'h0000_000A;                        // RULE8
    assign rise_ms = rise_w[21:0];
    assign fall_ms = tot_ms - rise_ms;                     // RULE9
    assign seg_ms  = fall_r ? fall_ms : rise_ms;

    // Phase walk: rise then fall, empty segments skipped
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            t_r    <= 22'd0;
            fall_r <= 1'b0;
        end else if (tot_ms == 22'd0) begin
            t_r    <= 22'd0;
            fall_r <= 1'b0;
        end else if (tick_r) begin
            if (t_r + 22'd1 >= seg_ms) begin
                t_r    <= 22'd0;
                fall_r <= ~fall_r;                         // RULE8 RULE9
            end else begin
                t_r <= t_r + 22'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // Shared serial divider: wobble ramp and length
    // ------------------------------------------------------------
    // One divider serves both jobs; a tick under 41 clocks skips updates
    assign rem_sh = {rem_r[DW-2:0], num_r[DW-1]};
    assign q_last = {num_r[DW-2:0], rem_sh >= {18'd0, den_r}};
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            job_r  <= S_IDLE;
            bit_r  <= 6'd0;
            num_r  <= {DW{1'b0}};
            rem_r  <= {DW{1'b0}};
            den_r  <= 22'd0;
            woff_r <= 17'd0;
            mlen_r <= 16'h0000;
            job_fall_r <= 1'b0;
            wfall_r    <= 1'b0;
        end else begin
            case (job_r)
                S_IDLE: begin
                    rem_r <= {DW{1'b0}};
                    bit_r <= 6'd0;
                    if (tick_r && seg_ms != 22'd0) begin
                        job_r <= S_WOB;
                        // End-of-tick offset lets the ramp reach the peak
                        num_r <= {6'd0, span} *
                                 {18'd0, t_r + 22'h00_0001};   // RULE18
                        job_fall_r <= fall_r;
                        den_r <= seg_ms;
                    end else if (len_dirty_r && ppm_r != 16'h0000) begin
                        job_r <= S_LEN;                    // RULE10
                        num_r <= {8'h00, pulses_r} * 40'd10;
                        den_r <= {6'd0, ppm_r};
                    end
                end
                S_WOB, S_LEN: begin
                    if (rem_sh >= {18'd0, den_r}) begin
                        rem_r <= rem_sh - {18'd0, den_r};
                        num_r <= {num_r[DW-2:0], 1'b1};
                    end else begin
                        rem_r <= rem_sh;
                        num_r <= {num_r[DW-2:0], 1'b0};
                    end
                    if (bit_r == DW - 1) begin
                        job_r <= S_IDLE;
                        if (job_r == S_WOB) begin
                            woff_r  <= (q_last >= {23'd0, span}) ?
                                       span : q_last[16:0];
                            wfall_r <= job_fall_r;
                        end else begin
                            mlen_r <= sat16(q_last);           // RULE10
                        end
                    end
                    bit_r <= bit_r + 6'd1;
                end
                default: job_r <= S_IDLE;
            endcase
            if (lrst) begin
                mlen_r <= 16'h0000;                        // RULE12
                // Drop a division still holding pulses from before the clear
                if (job_r == S_LEN)
                    job_r <= S_IDLE;                       // RULE12
            end
        end
    end

    // ------------------------------------------------------------
    // Length pulse accumulation
    // ------------------------------------------------------------
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pulses_r    <= 32'h0000_0000;
            len_dirty_r <= 1'b0;
        end else if (lrst) begin
            pulses_r    <= 32'h0000_0000;              // RULE12
            len_dirty_r <= 1'b0;
        end else begin
            if (l_edge && pulses_r != 32'hFFFF_FFFF)
                pulses_r <= pulses_r + 32'h0000_0001;
            if (l_edge)
                len_dirty_r <= 1'b1;
            else if (job_r == S_IDLE && !tick_r)
                len_dirty_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Frequency output with clamp
    // ------------------------------------------------------------
    // Ramps lo+kick..hi rising, hi-kick..lo falling
    always @* begin
        if (amp_r == 16'h0000 || tot_ms == 22'd0)
            f_calc = {2'b00, center_freq_in};              // RULE2
        else if (!wfall_r)
            f_calc = {2'b00, center_freq_in} - {1'b0, aw}
                     + {1'b0, kick} + {1'b0, woff_r};      // RULE1 RULE18
        else
            f_calc = {2'b00, center_freq_in} + {1'b0, aw}
                     - {1'b0, kick} - {1'b0, woff_r};      // RULE1 RULE18
    end

    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            freq_out <= 16'h0000;
        else if (f_calc[17] || f_calc < {2'b00, min_freq_in})
            freq_out <= min_freq_in;                       // RULE6
        else if (f_calc > {2'b00, max_freq_in})
            freq_out <= max_freq_in;                       // RULE6
        else
            freq_out <= f_calc[15:0];
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // No wait state: ready rises in the first access cycle
    assign rd_setup = psel_in & ~penable_in;
    assign wr_en    = psel_in & penable_in & pready_out & pwrite_in;
    assign mapped   = (paddr_in[1:0] == 2'b00) &&
                      (paddr_in <= `SWLCU_OFF_CTRL);

    always @* begin
        case (paddr_in)
            `SWLCU_OFF_REF:  rd_mux = {16'h0000, ref_r};
            `SWLCU_OFF_AMP:  rd_mux = {16'h0000, amp_r};
            `SWLCU_OFF_KICK: rd_mux = {16'h0000, kick_r};
            `SWLCU_OFF_PER:  rd_mux = {16'h0000, per_r};
            `SWLCU_OFF_RISE: rd_mux = {16'h0000, rise_r};
            `SWLCU_OFF_TLEN: rd_mux = {16'h0000, tlen_r};
            `SWLCU_OFF_MLEN: rd_mux = {16'h0000, mlen_r};
            `SWLCU_OFF_PPM:  rd_mux = {16'h0000, ppm_r};
            `SWLCU_OFF_FCNT: rd_mux = {16'h0000, fcnt_r};
            `SWLCU_OFF_ICNT: rd_mux = {16'h0000, icnt_r};
            `SWLCU_OFF_CNT:  rd_mux = {16'h0000, cnt_r};
            `SWLCU_OFF_STAT: rd_mux = {29'h0, stat_r};
            `SWLCU_OFF_MASK: rd_mux = {16'h0000, mask_r};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= rd_setup;
            pslverr_out <= rd_setup & ~mapped;
            // Writes return zero so a refused access never echoes data
            if (rd_setup)
                prdata_out <= pwrite_in ? 32'h0000_0000 : rd_mux;
        end
    end

    // Configuration registers; the measured length is set by hardware
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ref_r  <= 16'h0000;
            amp_r  <= 16'h0000;
            kick_r <= 16'h0000;
            per_r  <= `SWLCU_RST_PER;                      // RULE7
            rise_r <= `SWLCU_RST_RISE;
            tlen_r <= `SWLCU_RST_TLEN;
            ppm_r  <= `SWLCU_RST_PPM;
            fcnt_r <= `SWLCU_RST_FCNT;
            icnt_r <= `SWLCU_RST_ICNT;
            mask_r <= 16'h0000;
        end else if (wr_en) begin
            case (paddr_in)
                `SWLCU_OFF_REF:  ref_r  <= {15'h0000, pwdata_in[0]};
                `SWLCU_OFF_AMP:  amp_r  <= pwdata_in[15:0] >
                                 `SWLCU_PCT_FULL ? `SWLCU_PCT_FULL :
                                 pwdata_in[15:0];
                `SWLCU_OFF_KICK: kick_r <= pwdata_in[15:0];
                `SWLCU_OFF_PER:  per_r  <= pwdata_in[15:0] >
                                 `SWLCU_PER_MAX ? `SWLCU_PER_MAX :
                                 pwdata_in[15:0];          // RULE7
                `SWLCU_OFF_RISE: rise_r <= pwdata_in[15:0] >
                                 `SWLCU_PCT_FULL ? `SWLCU_PCT_FULL :
                                 pwdata_in[15:0];
                `SWLCU_OFF_TLEN: tlen_r <= pwdata_in[15:0];
                `SWLCU_OFF_PPM:  ppm_r  <= pwdata_in[15:0];
                `SWLCU_OFF_FCNT: fcnt_r <= pwdata_in[15:0];
                `SWLCU_OFF_ICNT: icnt_r <= pwdata_in[15:0];
                `SWLCU_OFF_MASK: mask_r <= {13'h0000, pwdata_in[2:0]};
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pulse counter
    // ------------------------------------------------------------
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            cnt_r <= 16'h0000;
        else if (wr_en && paddr_in == `SWLCU_OFF_CTRL &&
                 pwdata_in[`SWLCU_CTRL_CCLR])
            cnt_r <= 16'h0000;
        else if (c_edge && cnt_r < fcnt_r)
            cnt_r <= cnt_r + 16'h0001;                     // RULE15 RULE16
    end

    // ------------------------------------------------------------
    // Indications, sticky status and interrupt
    // ------------------------------------------------------------
    // Set wins over a write-one clear in the same cycle
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            length_arrive_out <= 1'b0;
            count_final_out   <= 1'b0;
            count_mid_out     <= 1'b0;
            stat_r            <= 3'b000;
            irq_out           <= 1'b0;
        end else begin
            length_arrive_out <= mlen_r > tlen_r;          // RULE11
            count_final_out   <= cnt_r >= fcnt_r;          // RULE15
            count_mid_out     <= cnt_r >= icnt_r;          // RULE16
            stat_r <= (stat_r & ~((wr_en &&
                      paddr_in == `SWLCU_OFF_STAT) ?
                      pwdata_in[2:0] : 3'b000)) |
                      {~count_mid_out & (cnt_r >= icnt_r),
                       ~count_final_out & (cnt_r >= fcnt_r),
                       ~length_arrive_out & (mlen_r > tlen_r)};
            irq_out <= |(stat_r & mask_r[2:0]);
        end
    end
endmodule // swlcu_top

// file: tb/swlcu_asserts.sv
// Port-level assertions for the swing, length and count unit
`timescale 1ns/1ps
module swlcu_chk (
    input wire        sys_clk_in,
    input wire        rst_b_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire [7:0]  paddr_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        pslverr_out,
    input wire [15:0] max_freq_in,
    input wire [15:0] min_freq_in,
    input wire        length_reset_in,
    input wire [15:0] freq_out,
    input wire        length_arrive_out,
    input wire        count_final_out,
    input wire        count_mid_out
);
    // ------------------------
    // One clock domain
    // ------------------------
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // Off the map or off a word boundary
    wire bad_a = paddr_in > 8'h34 || paddr_in[1:0] != 2'h0;

    AST_READY_ACC: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no ready in access cycle");
    AST_READY_ONLY: assert property (pready_out |-> psel_in && penable_in)
        else $error("ready outside access");
    AST_ERR_MAP: assert property (pready_out |-> pslverr_out == bad_a)
        else $error("error flag disagrees with address");
    AST_ERR_ZERO: assert property (pslverr_out |-> prdata_out == 32'h0)
        else $error("refused access returned data");
    // Late start: the command holds its reset value of zero until the first clock after reset
    AST_FREQ_CLAMP: assert property ($past(rst_b_in, 8) |->
        freq_out >= min_freq_in && freq_out <= max_freq_in)
        else $error("frequency outside limits");
    AST_LEN_CLEAR: assert property
        (length_reset_in [*6] |-> !length_arrive_out)
        else $error("length flag survives reset input");
    AST_FINAL_HOLD: assert property
        (count_final_out && !psel_in && !$past(psel_in) |=> count_final_out)
        else $error("final count flag dropped");
    AST_MID_FIN: assert property (count_final_out |-> count_mid_out)
        else $error("final flag without mid flag");

    // Main scenarios reached
    cover property (count_final_out && count_mid_out);
    cover property (length_arrive_out);
    cover property (pready_out && pslverr_out);
endmodule // swlcu_chk

bind swlcu_top swlcu_chk u_chk (.*);

// file: tb/swlcu_pulse_sensor.sv
// Pulse sensor model driving one counting input pin
`timescale 1ns/1ps
module swlcu_pulse_sensor (
    input  logic clk_in,
    output logic pulse_out
);
    // Idle low between bursts
    initial pulse_out = 1'h0;

    // Both phases last at least two clocks, slow senders stretch them
    task automatic send(input int n, input int hold);
        repeat (n) begin
            @(posedge clk_in);
            pulse_out <= 1'h1;
            repeat (hold < 2 ? 2 : hold) @(posedge clk_in);
            pulse_out <= 1'h0;
            repeat (hold < 2 ? 2 : hold) @(posedge clk_in);
        end
    endtask
endmodule // swlcu_pulse_sensor

// file: tb/swing_length_counting_unit_bench.sv
// Self-checking bench for the swing, length and count unit
`timescale 1ns/1ps
`include "swlcu_defines.vh"
module swing_length_counting_unit_bench;
    // ------------------------
    // Signals
    // ------------------------
    logic        clk, rst_b, psel, penable, pwrite, er;
    logic        pready, pslverr, larr, cfin, cmid, irq, lrst;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, lo, hi, md, pv;
    logic [31:0] rv [0:13];
    logic [15:0] cfreq, minf, maxf, freq;
    wire         cpls, lpls;
    int          mismatches, checks, cnt, n, i, nu, nd;

    // 20 MHz system clock
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    // Tick long enough for one ramp update each; 0.1 s is 4800 clocks
    swlcu_top #(.TICK_CYC(48)) DUT (
        .sys_clk_in        (clk),
        .rst_b_in          (rst_b),
        .psel_in           (psel),
        .penable_in        (penable),
        .pwrite_in         (pwrite),
        .paddr_in          (paddr),
        .pwdata_in         (pwdata),
        .prdata_out        (prdata),
        .pready_out        (pready),
        .pslverr_out       (pslverr),
        .center_freq_in    (cfreq),
        .max_freq_in       (maxf),
        .min_freq_in       (minf),
        .count_pulse_in    (cpls),
        .length_pulse_in   (lpls),
        .length_reset_in   (lrst),
        .freq_out          (freq),
        .length_arrive_out (larr),
        .count_final_out   (cfin),
        .count_mid_out     (cmid),
        .irq_out           (irq)
    );
    swlcu_pulse_sensor u_cnt (.clk_in(clk), .pulse_out(cpls));
    swlcu_pulse_sensor u_len (.clk_in(clk), .pulse_out(lpls));

    // ------------------------
    // Tasks
    // ------------------------
    task automatic close_out;
        if (mismatches == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t: word %h want %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t: flag %b want %b", $time, got, exp);
        end
    endtask

    // Idle edge first, so back-to-back calls never drive twice per step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'h1 && t < 16);
        if (pready !== 1'h1) begin
            mismatches++;
            $display("mismatch %0t: no ready", $time);
            close_out;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0000_0000);
        cmp_word(rd, exp);
    endtask

    // Extremes, largest jump and step directions over two periods
    task automatic watch;
        lo = 32'h0000_FFFF;
        hi = 32'h0000_0000;
        md = 32'h0000_0000;
        nu = 0;
        nd = 0;
        pv = freq;
        repeat (10000) begin
            @(posedge clk);
            if (freq < lo) lo = freq;
            if (freq > hi) hi = freq;
            if (freq > pv) nu++;
            if (freq < pv) nd++;
            if (freq > pv + md) md = freq - pv;
            if (freq + md < pv) md = pv - freq;
            pv = freq;
        end
    endtask

    // ------------------------
    // Sequence
    // ------------------------
    initial begin
        mismatches = 0;
        checks = 0;
        rst_b = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        cfreq = 16'h03E8;
        minf = 16'h0320;
        maxf = 16'h0BB8;
        lrst = 1'h0;
        i = $urandom(5);
        rv = '{'0, '0, '0, `SWLCU_RST_PER, `SWLCU_RST_RISE, `SWLCU_RST_TLEN,
               '0, `SWLCU_RST_PPM, `SWLCU_RST_FCNT, `SWLCU_RST_ICNT,
               '0, '0, '0, '0};
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        for (i = 0; i < 14; i++)
            rdc(8'(i * 4), rv[i]);
        apb(1'h0, 8'h38, 32'h0000_0000);
        cmp_bit(er, 1'h1);
        apb(1'h1, 8'h06, 32'h0000_0007);
        cmp_bit(er, 1'h1);
        // No swing: command is the centre itself
        cfreq <= 16'h05DC;
        repeat (12) @(posedge clk);
        cmp_word({16'h0000, freq}, 32'h0000_05DC);
        cfreq <= 16'h03E8;
        // Swing 10 % of centre 1000, kick half the swing
        apb(1'h1, `SWLCU_OFF_KICK, 32'h0000_01F4);
        apb(1'h1, `SWLCU_OFF_PER, 32'h0000_0001);
        apb(1'h1, `SWLCU_OFF_AMP, 32'h0000_0064);
        watch;
        cmp_word(hi, 32'h0000_044C);
        cmp_word(lo, 32'h0000_0384);
        cmp_bit(md >= 32'h0000_0032, 1'h1);
        // Swing from maximum 3000, low end held at 800, 20 % rise
        apb(1'h1, `SWLCU_OFF_REF, 32'h0000_0001);
        apb(1'h1, `SWLCU_OFF_RISE, 32'h0000_00C8);
        watch;
        cmp_word(hi, 32'h0000_0514);
        cmp_word(lo, 32'h0000_0320);
        cmp_bit(md >= 32'h0000_0096, 1'h1);
        cmp_bit(nu * 2 < nd, 1'h1);
        apb(1'h1, `SWLCU_OFF_AMP, 32'h0000_0000);
        // Mid mark at 3, stop at 5, pulses of random width
        apb(1'h1, `SWLCU_OFF_ICNT, 32'h0000_0003);
        apb(1'h1, `SWLCU_OFF_FCNT, 32'h0000_0005);
        apb(1'h1, `SWLCU_OFF_CTRL, 32'h0000_0001);
        cnt = 0;
        repeat (7) begin
            u_cnt.send(1, 2 + $urandom % 3);
            repeat (6) @(posedge clk);
            cnt = cnt < 5 ? cnt + 1 : 5;
            rdc(`SWLCU_OFF_CNT, cnt);
            cmp_bit(cmid, cnt >= 3);
            cmp_bit(cfin, cnt >= 5);
        end
        // Count is read-only; events reach the interrupt through the mask
        apb(1'h1, `SWLCU_OFF_CNT, 32'h0000_0000);
        rdc(`SWLCU_OFF_CNT, 32'h0000_0005);
        rdc(`SWLCU_OFF_STAT, 32'h0000_0006);
        cmp_bit(irq, 1'h0);
        apb(1'h1, `SWLCU_OFF_MASK, 32'h0000_0002);
        rdc(`SWLCU_OFF_MASK, 32'h0000_0002);
        cmp_bit(irq, 1'h1);
        apb(1'h1, `SWLCU_OFF_STAT, 32'h0000_0002);
        rdc(`SWLCU_OFF_STAT, 32'h0000_0004);
        cmp_bit(irq, 1'h0);
        // Two pulses a metre; target at the length, then one below
        apb(1'h1, `SWLCU_OFF_PPM, 32'h0000_0014);
        n = 4 + $urandom % 5;
        u_len.send(n, 2);
        repeat (200) @(posedge clk);
        rdc(`SWLCU_OFF_MLEN, n * 10 / 20);
        for (i = 0; i < 2; i++) begin
            apb(1'h1, `SWLCU_OFF_TLEN, n / 2 - i);
            repeat (3) @(posedge clk);
            cmp_bit(larr, i == 1);
        end
        lrst <= 1'h1;
        repeat (8) @(posedge clk);
        rdc(`SWLCU_OFF_MLEN, 32'h0000_0000);
        cmp_bit(larr, 1'h0);
        lrst <= 1'h0;
        u_len.send(3, 3);
        repeat (200) @(posedge clk);
        rdc(`SWLCU_OFF_MLEN, 32'h0000_0001);
        close_out;
    end

    // Watchdog against a hung sequence
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        $display("mismatch %0t: run overtime", $time);
        close_out;
    end
endmodule // swing_length_counting_unit_bench
